// file: design/sfpe_pkg.sv
// Shared constants and types for the flash program/erase command link
package sfpe_pkg;
    localparam logic [7:0] SFPE_OP_PROG_ERASE  = 8'h83;
    localparam logic [7:0] SFPE_OP_PROG_NOERASE = 8'h88;
    localparam logic [7:0] SFPE_OP_PAGE_ERASE  = 8'h81;
    localparam logic [7:0] SFPE_OP_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] SFPE_OP_SECTOR_ERASE = 8'h7c;
    localparam int SFPE_ADDR_BITS      = 24;
    // Page field starts: standard mode skips 5 bits, binary mode skips 6
    localparam int SFPE_STD_PAGE_LSB   = 9;
    localparam int SFPE_BIN_PAGE_LSB   = 8;
    localparam int SFPE_PAGE_BITS      = 10;
    // Timing figures in microseconds and their cycle counts at 100 MHz
    localparam int SFPE_CLK_MHZ        = 100;
    localparam int SFPE_ERASE_PROGRAM_TIME_US = 40;
    localparam int SFPE_PROGRAM_TIME_US       = 20;
    localparam int SFPE_PAGE_ERASE_TIME_US    = 20;
    localparam int SFPE_BLOCK_ERASE_TIME_US   = 50;
    localparam int SFPE_SECTOR_ERASE_TIME_US  = 80;
    localparam int SFPE_ERASE_PROGRAM_CYC = SFPE_ERASE_PROGRAM_TIME_US * SFPE_CLK_MHZ;
    localparam int SFPE_PROGRAM_CYC       = SFPE_PROGRAM_TIME_US * SFPE_CLK_MHZ;
    localparam int SFPE_PAGE_ERASE_CYC    = SFPE_PAGE_ERASE_TIME_US * SFPE_CLK_MHZ;
    localparam int SFPE_BLOCK_ERASE_CYC   = SFPE_BLOCK_ERASE_TIME_US * SFPE_CLK_MHZ;
    localparam int SFPE_SECTOR_ERASE_CYC  = SFPE_SECTOR_ERASE_TIME_US * SFPE_CLK_MHZ;
    localparam int SFPE_SCK_DIV        = 4;
    localparam int SFPE_CMD_BITS       = 32;

    typedef enum logic [2:0] {
        SFPE_OP_NONE   = 3'h0,
        SFPE_OP_PGM_E  = 3'h1,
        SFPE_OP_PGM_NE = 3'h2,
        SFPE_OP_PG_ER  = 3'h3,
        SFPE_OP_BLK_ER = 3'h4,
        SFPE_OP_SEC_ER = 3'h5
    } sfpe_op_t;

    // Decode opcode byte to operation
    function automatic sfpe_op_t sfpe_decode(input logic [7:0] code);
        case (code)
            SFPE_OP_PROG_ERASE:   sfpe_decode = SFPE_OP_PGM_E;
            SFPE_OP_PROG_NOERASE: sfpe_decode = SFPE_OP_PGM_NE;
            SFPE_OP_PAGE_ERASE:   sfpe_decode = SFPE_OP_PG_ER;
            SFPE_OP_BLOCK_ERASE:  sfpe_decode = SFPE_OP_BLK_ER;
            SFPE_OP_SECTOR_ERASE: sfpe_decode = SFPE_OP_SEC_ER;
            default:              sfpe_decode = SFPE_OP_NONE;
        endcase
    endfunction

    // Extract the 10-bit page from the 24-bit address
    function automatic logic [9:0] sfpe_page(input logic [23:0] addr, input logic binary);
        sfpe_page = binary ? addr[SFPE_BIN_PAGE_LSB +: SFPE_PAGE_BITS]
                           : addr[SFPE_STD_PAGE_LSB +: SFPE_PAGE_BITS];
    endfunction
endpackage

// file: design/sfpe_if.sv
// Serial command link between host controller and flash device
`timescale 1ns/1ns
`default_nettype none
interface sfpe_if;
    logic cs_n;
    logic sck;
    logic si;
    modport host (output cs_n, output sck, output si);
    modport dev  (input cs_n, input sck, input si);
endinterface
`default_nettype wire

// file: design/sfpe_device.sv
// Flash device end: command capture, address decode and self-timed busy
//
// Summary of operation
// - 83H: program with erase, standard page field
// - Binary mode: page field shifted one bit
// - Erase-then-program starts on chip select rise
// - Busy held until internal operation finishes
// - 88H: program without erase, same layout
// - Host erases page before no-erase program
// - 81H: page erase, same page layout
// - 50H: block erase, seven upper page bits
// - Block index ignores three low page bits
// - 7CH: sector 0a/0b by page bit 3
// - Sectors 1-7 from three top page bits
// - Sector erase erases exactly one sector
`timescale 1ns/1ns
`default_nettype none
module sfpe_device
    import sfpe_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    sfpe_if.dev              link,
    input  wire logic        i_binary_page,
    output logic             o_busy,
    output logic             o_start,
    output logic [2:0]       o_op,
    output logic [9:0]       o_page,
    output logic             o_erase_first,
    output logic [6:0]       o_block,
    output logic [3:0]       o_sector
);
    typedef enum logic [1:0] {
        SFPE_ST_IDLE = 2'b00,
        SFPE_ST_SHIFT = 2'b01,
        SFPE_ST_BUSY = 2'b11
    } sfpe_dstate_t;

    sfpe_dstate_t st_q, st_d;
    logic [31:0]  sr_q, sr_d;
    logic [5:0]   cnt_q, cnt_d;
    logic [19:0]  tmr_q, tmr_d;
    logic         sck_q, sck_d;
    logic         cs_q, cs_d;
    logic         start_q, start_d;
    logic [2:0]   op_q, op_d;
    logic [9:0]   page_q, page_d;
    logic         erase_q, erase_d;
    logic [6:0]   block_q, block_d;
    logic [3:0]   sector_q, sector_d;
    sfpe_op_t     op_dec;
    logic [9:0]   page_dec;
    logic         sck_rise, cs_rise;
    logic         accept;
    logic         tmr_done;

    // Sector code: 0 and 1 split sector 0, sectors 1-7 become 2-8
    function automatic logic [3:0] sfpe_sector_of(input logic [9:0] pg);
        if (pg[9:7] == 3'h0) begin
            sfpe_sector_of = {3'h0, pg[3]};
        end else begin
            sfpe_sector_of = {1'b0, pg[9:7]} + 4'h1;
        end
    endfunction

    // Busy span of each operation in clock cycles
    function automatic logic [19:0] sfpe_op_cycles(input sfpe_op_t op);
        case (op)
            SFPE_OP_PGM_E:  sfpe_op_cycles = 20'(SFPE_ERASE_PROGRAM_CYC);
            SFPE_OP_PGM_NE: sfpe_op_cycles = 20'(SFPE_PROGRAM_CYC);
            SFPE_OP_PG_ER:  sfpe_op_cycles = 20'(SFPE_PAGE_ERASE_CYC);
            SFPE_OP_BLK_ER: sfpe_op_cycles = 20'(SFPE_BLOCK_ERASE_CYC);
            default:        sfpe_op_cycles = 20'(SFPE_SECTOR_ERASE_CYC);
        endcase
    endfunction

    // A frame counts only with all 32 bits and a known code
    function automatic logic sfpe_frame_ok(input logic [5:0] bits, input sfpe_op_t op);
        sfpe_frame_ok = (bits == 6'(SFPE_CMD_BITS)) && (op != SFPE_OP_NONE);
    endfunction

    // Previous pin levels for edge detection, reset to the idle levels
    always_comb begin
        sck_d = link.sck;
        cs_d  = link.cs_n;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            sck_q <= 1'b0;
            cs_q  <= 1'b1;
        end else begin
            sck_q <= sck_d;
            cs_q  <= cs_d;
        end
    end

    assign sck_rise = link.sck & ~sck_q;
    assign cs_rise  = link.cs_n & ~cs_q;
    assign op_dec   = sfpe_decode(sr_q[31:24]);
    assign page_dec = sfpe_page(sr_q[23:0], i_binary_page);
    // Incomplete or unknown command starts nothing
    assign accept   = (st_q == SFPE_ST_SHIFT) && cs_rise
                      && sfpe_frame_ok(cnt_q, op_dec);
    assign tmr_done = (tmr_q <= 20'h00001);

    // Frame capture and operating state
    always_comb begin
        st_d  = st_q;
        sr_d  = sr_q;
        cnt_d = cnt_q;
        case (st_q)
            SFPE_ST_IDLE: begin
                cnt_d = '0;
                if (!link.cs_n) begin
                    st_d = SFPE_ST_SHIFT;
                end
            end
            SFPE_ST_SHIFT: begin
                // Bits beyond the 32nd are ignored
                if (sck_rise && cnt_q < 6'(SFPE_CMD_BITS)) begin
                    sr_d  = {sr_q[30:0], link.si};
                    cnt_d = cnt_q + 6'h01;
                end
                if (cs_rise) begin
                    st_d = accept ? SFPE_ST_BUSY : SFPE_ST_IDLE;
                end
            end
            SFPE_ST_BUSY: begin
                // Link ignored until the self-timed work ends
                if (tmr_done) begin
                    st_d = SFPE_ST_IDLE;
                end
            end
            default: st_d = SFPE_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            st_q  <= SFPE_ST_IDLE;
            sr_q  <= '0;
            cnt_q <= '0;
        end else begin
            st_q  <= st_d;
            sr_q  <= sr_d;
            cnt_q <= cnt_d;
        end
    end

    // Self-timed span: loaded on acceptance, counted down while busy
    always_comb begin
        tmr_d = tmr_q;
        if (accept) begin
            tmr_d = sfpe_op_cycles(op_dec);
        end else if (st_q == SFPE_ST_BUSY) begin
            tmr_d = tmr_done ? 20'h00000 : tmr_q - 20'h00001;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_d;
        end
    end

    // Decoded operation, held until the next accepted command
    always_comb begin
        start_d  = accept;
        op_d     = op_q;
        page_d   = page_q;
        erase_d  = erase_q;
        block_d  = block_q;
        sector_d = sector_q;
        if (accept) begin
            op_d     = op_dec;
            page_d   = page_dec;
            erase_d  = (op_dec == SFPE_OP_PGM_E);
            block_d  = page_dec[9:3];
            sector_d = sfpe_sector_of(page_dec);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            start_q  <= 1'b0;
            op_q     <= 3'h0;
            page_q   <= '0;
            erase_q  <= 1'b0;
            block_q  <= '0;
            sector_q <= '0;
        end else begin
            start_q  <= start_d;
            op_q     <= op_d;
            page_q   <= page_d;
            erase_q  <= erase_d;
            block_q  <= block_d;
            sector_q <= sector_d;
        end
    end

    assign o_busy        = (st_q == SFPE_ST_BUSY);
    assign o_start       = start_q;
    assign o_op          = op_q;
    assign o_page        = page_q;
    assign o_erase_first = erase_q;
    assign o_block       = block_q;
    assign o_sector      = sector_q;
endmodule
`default_nettype wire

// file: design/sfpe_host.sv
// Host end: serialises one opcode and three address bytes per request
`timescale 1ns/1ns
`default_nettype none
module sfpe_host
    import sfpe_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    sfpe_if.host             link,
    input  wire logic        i_binary_page,
    input  wire logic        i_req,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [9:0]  i_page,
    output logic             o_ready,
    output logic             o_done
);
    typedef enum logic [1:0] {
        SFPE_HS_IDLE = 2'b00,
        SFPE_HS_SEND = 2'b01,
        SFPE_HS_END  = 2'b11
    } sfpe_hstate_t;

    sfpe_hstate_t st_q, st_d;
    logic [31:0]  sr_q, sr_d;
    logic [5:0]   cnt_q, cnt_d;
    logic [1:0]   div_q, div_d;
    logic         sck_q, sck_d;
    logic         cs_n_q, cs_n_d;
    logic         done_q, done_d;
    logic [23:0]  addr;

    // Page placed after 5 or 6 leading ignored bits
    always_comb begin
        addr = '0;
        if (i_binary_page) begin
            addr[SFPE_BIN_PAGE_LSB +: SFPE_PAGE_BITS] = i_page;
        end else begin
            addr[SFPE_STD_PAGE_LSB +: SFPE_PAGE_BITS] = i_page;
        end
    end

    always_comb begin
        st_d   = st_q;
        sr_d   = sr_q;
        cnt_d  = cnt_q;
        div_d  = div_q;
        sck_d  = sck_q;
        cs_n_d = cs_n_q;
        done_d = 1'b0;
        case (st_q)
            SFPE_HS_IDLE: begin
                if (i_req) begin
                    st_d   = SFPE_HS_SEND;
                    sr_d   = {i_opcode, addr};
                    cnt_d  = '0;
                    div_d  = '0;
                    cs_n_d = 1'b0;
                    sck_d  = 1'b0;
                end
            end
            SFPE_HS_SEND: begin
                div_d = div_q + 2'h1;
                if (div_q == 2'(SFPE_SCK_DIV - 1)) begin
                    sck_d = ~sck_q;
                    if (sck_q) begin
                        sr_d  = {sr_q[30:0], 1'b0};
                        cnt_d = cnt_q + 6'h01;
                        if (cnt_q == 6'(SFPE_CMD_BITS - 1)) begin
                            st_d = SFPE_HS_END;
                        end
                    end
                end
            end
            SFPE_HS_END: begin
                cs_n_d = 1'b1;
                done_d = 1'b1;
                st_d   = SFPE_HS_IDLE;
            end
            default: st_d = SFPE_HS_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            st_q   <= SFPE_HS_IDLE;
            sr_q   <= '0;
            cnt_q  <= '0;
            div_q  <= '0;
            sck_q  <= 1'b0;
            cs_n_q <= 1'b1;
            done_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            sr_q   <= sr_d;
            cnt_q  <= cnt_d;
            div_q  <= div_d;
            sck_q  <= sck_d;
            cs_n_q <= cs_n_d;
            done_q <= done_d;
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sck  = sck_q;
    assign link.si   = sr_q[31];
    assign o_ready   = (st_q == SFPE_HS_IDLE);
    assign o_done    = done_q;
endmodule
`default_nettype wire

// file: test/sfpe_monitor.sv
// Checker for the command link and the device busy handshake
`timescale 1ns/1ns
`default_nettype none
module sfpe_monitor (
    input  wire logic i_clk_sys,
    input  wire logic i_resetn,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic o_busy,
    input  wire logic o_start,
    input  wire logic o_done
);
    logic [5:0]  rises_q, rises_d;
    logic [13:0] bcnt_q, bcnt_d;
    logic        sck_q, sck_d;
    always_comb begin
        sck_d   = i_resetn & sck;
        rises_d = (!i_resetn || cs_n) ? 6'h0 : rises_q + 6'(sck & ~sck_q);
        bcnt_d  = (i_resetn && o_busy) ? bcnt_q + 14'h1 : 14'h0;
    end
    always_ff @(posedge i_clk_sys) begin
        sck_q   <= sck_d;
        rises_q <= rises_d;
        bcnt_q  <= bcnt_d;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    sequence s_cs_end; $rose(cs_n); endsequence
    sequence s_launch; o_start ##1 o_busy; endsequence
    chk_frame_bits: assert property (s_cs_end |-> rises_q == 6'd32)
        else $error("frame did not carry 32 clock rises");
    chk_sck_idle: assert property (cs_n && $past(cs_n) |-> !sck)
        else $error("serial clock moved outside a frame");
    chk_si_steady: assert property ($rose(sck) && !cs_n |-> $stable(si))
        else $error("data changed at clock rise");
    chk_start_cs_rise: assert property (o_start |-> $past(cs_n) && !$past(cs_n, 2))
        else $error("start not one cycle after chip select rise");
    chk_done_at_end: assert property (o_done == $rose(cs_n))
        else $error("host done pulse not at chip select rise");
    chk_start_busy: assert property (o_start |-> o_busy)
        else $error("start without busy");
    chk_busy_cause: assert property ($rose(o_busy) |-> o_start)
        else $error("busy rose without start");
    chk_start_pulse: assert property (s_launch |-> !o_start)
        else $error("start longer than one cycle");
    chk_busy_deaf: assert property (o_start |-> !$past(o_busy))
        else $error("command taken while busy");
    chk_busy_len: assert property ($fell(o_busy) |-> bcnt_q inside
        {[1999:2001], [3999:4001], [4999:5001], [7999:8001]})
        else $error("busy span matches no operation time");
endmodule
`default_nettype wire

// file: test/serial_flash_program_erase_cmds_tb.sv
// Bench joining host and device, plus a second device driven by hand
`timescale 1ns/1ns
`default_nettype none
module serial_flash_program_erase_cmds_tb;
    import sfpe_pkg::*;
    typedef struct packed {
        logic [2:0] op;
        logic [9:0] pg;
        logic       ef;
        logic [6:0] blk;
        logic [3:0] sec;
    } sfpe_exp_t;
    logic        i_clk_sys, i_resetn, bin, req, ready, done, busy, start, ef, start2;
    logic [7:0]  opc;
    logic [9:0]  page, o_page, pg;
    logic [2:0]  o_op;
    logic [6:0]  blk;
    logic [3:0]  sec;
    logic [31:0] rng;
    logic [7:0]  codes [5];
    int          fail_count, n_compared, starts2;
    sfpe_exp_t   expq[$], got, e;
    sfpe_if      link();
    sfpe_if      link2();
    sfpe_host i_sfpe_host (.i_clk_sys, .i_resetn, .link(link.host), .i_binary_page(bin),
        .i_req(req), .i_opcode(opc), .i_page(page), .o_ready(ready), .o_done(done));
    sfpe_device i_sfpe_device (.i_clk_sys, .i_resetn, .link(link.dev), .i_binary_page(bin),
        .o_busy(busy), .o_start(start), .o_op, .o_page, .o_erase_first(ef),
        .o_block(blk), .o_sector(sec));
    sfpe_device i_sfpe_device_b (.i_clk_sys, .i_resetn, .link(link2.dev),
        .i_binary_page(bin), .o_busy(), .o_start(start2), .o_op(), .o_page(),
        .o_erase_first(), .o_block(), .o_sector());
    sfpe_monitor i_sfpe_monitor (.i_clk_sys, .i_resetn, .cs_n(link.cs_n), .sck(link.sck),
        .si(link.si), .o_busy(busy), .o_start(start), .o_done(done));
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_idle(input bit dev);
        int k;
        k = 0;
        repeat (4) @(negedge i_clk_sys);
        while (!(ready === 1'b1 && link.cs_n === 1'b1 && (!dev || busy === 1'b0))
               && k < 10000) begin
            @(negedge i_clk_sys);
            k++;
        end
        if (k >= 10000) begin
            check("timeout", 16'h1, 16'h0);
            close_out();
        end
    endtask
    task automatic send(input logic [7:0] o, input logic [9:0] p);
        req = 1'b1;
        opc = o;
        page = p;
        @(negedge i_clk_sys);
        req = 1'b0;
        wait_idle(1'b0);
    endtask
    // Hand-driven frame on the second link, n bits MSB first
    task automatic frame2(input int n, input logic [31:0] w);
        link2.cs_n = 1'b0;
        for (int k = 0; k < n; k++) begin
            link2.si = w[31-k];
            repeat (4) @(negedge i_clk_sys);
            link2.sck = 1'b1;
            repeat (4) @(negedge i_clk_sys);
            link2.sck = 1'b0;
        end
        repeat (4) @(negedge i_clk_sys);
        link2.cs_n = 1'b1;
        link2.si = ~link2.si;
        repeat (10) @(negedge i_clk_sys);
    endtask
    always @(negedge i_clk_sys) begin
        if (start === 1'b1) begin
            if (expq.size() == 0) check("start", 16'h1, 16'h0);
            else begin
                got = expq.pop_front();
                check("op", 16'(o_op), 16'(got.op));
                check("page", 16'(o_page), 16'(got.pg));
                check("erase", 16'(ef), 16'(got.ef));
                if (got.op == 3'h4) check("block", 16'(blk), 16'(got.blk));
                if (got.op == 3'h5) check("sector", 16'(sec), 16'(got.sec));
            end
        end
        if (start2 === 1'b1) starts2++;
    end
    initial begin
        codes = '{8'h83, 8'h88, 8'h81, 8'h50, 8'h7c};
        {i_resetn, bin, req, opc, page, starts2, fail_count, n_compared} = '0;
        {link2.cs_n, link2.sck, link2.si} = 3'b100;
        rng = 32'ha4ae3659;
        repeat (3) @(negedge i_clk_sys);
        i_resetn = 1'b1;
        for (int i = 0; i < 10; i++) begin
            rng = xs(rng);
            bin = i[0];
            pg = rng[9:0];
            if (i == 8) pg[9:7] = 3'h0;
            e.pg = pg;
            e.blk = pg[9:3];
            e.sec = (pg[9:7] == 3'h0) ? {3'h0, pg[3]} : 4'(pg[9:7]) + 4'h1;
            if (i / 2 == 1) begin
                // Target page erased before the no-erase program
                e.op = 3'h3;
                e.ef = 1'b0;
                expq.push_back(e);
                send(8'h81, pg);
                wait_idle(1'b1);
            end
            e.op = 3'(i / 2 + 1);
            e.ef = (i < 2);
            expq.push_back(e);
            send(codes[i / 2], pg);
            send(8'h81, ~pg);
            wait_idle(1'b1);
            send(8'h84, pg);
            wait_idle(1'b1);
        end
        check("left", 16'(expq.size()), 16'h0);
        frame2(24, {8'h81, 24'h0});
        check("short", 16'(starts2), 16'h0);
        frame2(32, {8'h81, 24'h0});
        check("full", 16'(starts2), 16'h1);
        close_out();
    end
endmodule
`default_nettype wire
